// ===== output_compare_mode_logic.sv
`timescale 1ns/1ps
module output_compare_mode_logic (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire ocmp_pkg::reg_req_t          req,
  output logic      [ocmp_pkg::CTL_W-1:0]  rdata,
  input  wire logic                        trigger_event,
  output logic      [ocmp_pkg::TMR_W-1:0]  channel_timer_value,
  output logic                             compare_output_pin
);
  import ocmp_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10,
    ST_DONE   = 2'b11
  } seq_state_t;

  logic [CTL_W-1:0] compare_control_one;
  logic             trigger_status_flag;
  logic [TMR_W-1:0] primary_shadow;
  logic [TMR_W-1:0] primary_compare_value;
  logic [TMR_W-1:0] secondary_shadow;
  logic [TMR_W-1:0] secondary_compare_value;
  seq_state_t       state;
  seq_state_t       next_state;
  logic             next_pin;
  compare_mode_t    prev_mode;

  wire compare_mode_t compare_mode_select =
    compare_mode_t'(compare_control_one[MODE_MSB:MODE_LSB]);
  wire trigger_status_clear_mode = compare_control_one[TRIG_MODE_BIT];

  wire wr_ctl_one = req.wr & (req.addr == ADDR_CTL_ONE);
  wire wr_primary = req.wr & (req.addr == ADDR_PRIMARY);
  wire wr_second  = req.wr & (req.addr == ADDR_SECONDARY);
  wire wr_ctl_two = req.wr & (req.addr == ADDR_CTL_TWO);
  wire wr_timer   = req.wr & (req.addr == ADDR_TIMER);

  wire is_pwm = (compare_mode_select == MODE_PWM_EDGE) |
                (compare_mode_select == MODE_PWM_CTR);
  wire enabled = (compare_mode_select != MODE_OFF);
  wire mode_changed = (compare_mode_select != prev_mode);
  wire start_high = (compare_mode_select == MODE_ONE_LOW);

  wire match_primary = enabled &
                       (channel_timer_value == primary_compare_value);
  wire match_second  = enabled &
                       (channel_timer_value == secondary_compare_value);
  wire match_zero    = enabled & (channel_timer_value == TMR_ZERO);

  // pwm period restarts when the timer wraps to zero
  wire pwm_reload = is_pwm & match_zero;

  cmp_reg u_primary (
    .clk      (clk),
    .rst      (rst),
    .wr       (wr_primary),
    .wdata    (req.wdata),
    .buffered (is_pwm),
    .reload   (pwm_reload),
    .shadow   (primary_shadow),
    .active   (primary_compare_value)
  );

  cmp_reg u_secondary (
    .clk      (clk),
    .rst      (rst),
    .wr       (wr_second),
    .wdata    (req.wdata),
    .buffered (is_pwm),
    .reload   (pwm_reload),
    .shadow   (secondary_shadow),
    .active   (secondary_compare_value)
  );

  // register file
  always_ff @(posedge clk) begin
    if (rst) begin
      compare_control_one <= CTL_RESET;
    end else if (wr_ctl_one) begin
      compare_control_one <= {{(CTL_W-CTL_ONE_USED){1'b0}},
                              req.wdata[CTL_ONE_USED-1:0]};
    end
  end

  // channel timer, counts only while the mode is not off and holds otherwise, software may preset it
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_timer_value <= TMR_ZERO;
    end else if (wr_timer) begin
      channel_timer_value <= req.wdata;
    end else if (enabled) begin
      channel_timer_value <= channel_timer_value + 16'h0001;
    end
  end

  wire hw_clear = trigger_status_clear_mode & match_second;
  wire sw_clear = wr_ctl_two & ~req.wdata[TRIG_STAT_BIT];
  wire sw_set   = wr_ctl_two & req.wdata[TRIG_STAT_BIT];

  // set wins over any clear
  always_ff @(posedge clk) begin
    if (rst) begin
      trigger_status_flag <= 1'b0;
    end else if (trigger_event | sw_set) begin
      trigger_status_flag <= 1'b1;
    end else if (hw_clear | sw_clear) begin
      trigger_status_flag <= 1'b0;
    end
  end

  wire [CTL_W-1:0] ctl_two_read =
    {{(CTL_W-TRIG_STAT_BIT-1){1'b0}}, trigger_status_flag,
     {TRIG_STAT_BIT{1'b0}}};
  wire sel_ctl_one = req.addr == ADDR_CTL_ONE;
  wire sel_primary = req.addr == ADDR_PRIMARY;
  wire sel_second  = req.addr == ADDR_SECONDARY;
  wire sel_ctl_two = req.addr == ADDR_CTL_TWO;
  wire sel_timer   = req.addr == ADDR_TIMER;
  wire [CTL_W-1:0] read_mux =
    sel_ctl_one ? compare_control_one :
    sel_primary ? primary_shadow :
    sel_second  ? secondary_shadow :
    sel_ctl_two ? ctl_two_read :
    sel_timer   ? channel_timer_value : CTL_RESET;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= CTL_RESET;
    end else if (req.rd) begin
      rdata <= read_mux;
    end else begin
      rdata <= CTL_RESET;
    end
  end

  // output sequencing, evaluated every cycle
  always_comb begin
    next_state = state;
    next_pin = compare_output_pin;
    if (!enabled) begin
      next_state = ST_IDLE;
      next_pin = 1'b0;
    end else if (mode_changed) begin
      next_state = ST_FIRST;
      next_pin = start_high;
    end else begin
      case (compare_mode_select)
        MODE_ONE_HIGH: begin
          if (state == ST_FIRST && match_primary) begin
            next_pin = 1'b1;
            next_state = ST_DONE;
          end
        end
        MODE_ONE_LOW: begin
          if (state == ST_FIRST && match_primary) begin
            next_pin = 1'b0;
            next_state = ST_DONE;
          end
        end
        MODE_TOGGLE: begin
          if (match_primary) begin
            next_pin = ~compare_output_pin;
          end
        end
        MODE_DBL_SHOT: begin
          if (state == ST_FIRST && match_primary) begin
            next_pin = 1'b1;
            next_state = ST_SECOND;
          end else if (state == ST_SECOND && match_second) begin
            next_pin = 1'b0;
            next_state = ST_DONE;
          end
        end
        MODE_DBL_CONT: begin
          if (state == ST_FIRST && match_primary) begin
            next_pin = 1'b1;
            next_state = ST_SECOND;
          end else if (state == ST_SECOND && match_second) begin
            next_pin = 1'b0;
            next_state = ST_FIRST;
          end
        end
        MODE_PWM_EDGE: begin
          if (match_primary) begin
            next_pin = 1'b0;
          end else if (match_zero) begin
            next_pin = 1'b1;
          end
        end
        MODE_PWM_CTR: begin
          if (match_second) begin
            next_pin = 1'b0;
          end else if (match_primary) begin
            next_pin = 1'b1;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      compare_output_pin <= 1'b0;
      prev_mode <= MODE_OFF;
    end else begin
      state <= next_state;
      compare_output_pin <= next_pin;
      prev_mode <= compare_mode_select;
    end
  end

  sequence s_dbl_armed;
    compare_mode_select == MODE_DBL_SHOT && !mode_changed &&
    state == ST_FIRST && match_primary;
  endsequence

  sequence s_pin_high_wait;
    ##1 compare_output_pin && state == ST_SECOND;
  endsequence

  chk_flag_hw_clear: assert property (@(posedge clk)
    disable iff (rst)
    hw_clear && !trigger_event && !sw_set |=> !trigger_status_flag)
    else $error("trigger flag not cleared on secondary match");

  chk_flag_sticky: assert property (@(posedge clk)
    disable iff (rst)
    !trigger_status_clear_mode && trigger_status_flag && !wr_ctl_two
    && !$past(wr_ctl_one) |=> trigger_status_flag)
    else $error("trigger flag cleared by hardware");

  chk_center_pwm: assert property (@(posedge clk)
    disable iff (rst)
    compare_mode_select == MODE_PWM_CTR && !mode_changed && match_primary
    && !match_second |=> compare_output_pin)
    else $error("center pwm output not set on primary match");

  chk_edge_pwm: assert property (@(posedge clk) disable iff (rst)
    compare_mode_select == MODE_PWM_EDGE && !mode_changed && match_primary
    |=> !compare_output_pin)
    else $error("edge pwm output not cleared on primary match");

  chk_dbl_cont: assert property (@(posedge clk) disable iff (rst)
    compare_mode_select == MODE_DBL_CONT && !mode_changed &&
    state == ST_SECOND && match_second |=> !compare_output_pin
    && state == ST_FIRST)
    else $error("continuous pulse did not rearm");

  chk_dbl_shot: assert property (@(posedge clk) disable iff (rst)
    s_dbl_armed |-> s_pin_high_wait)
    else $error("single shot pulse did not start");

  chk_toggle: assert property (@(posedge clk) disable iff (rst)
    compare_mode_select == MODE_TOGGLE && !mode_changed && match_primary
    |=> compare_output_pin != $past(compare_output_pin))
    else $error("output not toggled on primary match");

  chk_init_high: assert property (@(posedge clk) disable iff (rst)
    compare_mode_select == MODE_ONE_LOW && mode_changed
    |=> compare_output_pin && state == ST_FIRST)
    else $error("force low mode did not start high");

  chk_force_high: assert property (@(posedge clk)
    disable iff (rst)
    compare_mode_select == MODE_ONE_HIGH && !mode_changed &&
    state == ST_FIRST && match_primary |=> compare_output_pin
    && state == ST_DONE)
    else $error("force high mode missed match");

  chk_disabled: assert property (@(posedge clk) disable iff (rst)
    !enabled |=> !compare_output_pin)
    else $error("disabled channel drives output");

  chk_buffered: assert property (@(posedge clk) disable iff (rst)
    is_pwm && !pwm_reload && $past(is_pwm)
    |=> $stable(primary_compare_value))
    else $error("pwm compare value changed mid period");

  chk_direct_load: assert property (@(posedge clk)
    disable iff (rst)
    wr_primary && !is_pwm |=> primary_compare_value == $past(req.wdata))
    else $error("compare write not applied directly");
endmodule

// ===== ocmp_pkg.sv
package ocmp_pkg;
  localparam int TMR_W = 16;
  localparam int CTL_W = 16;
  localparam int ADDR_W = 4;

  localparam logic [ADDR_W-1:0] ADDR_CTL_ONE = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_PRIMARY = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_SECONDARY = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CTL_TWO = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_TIMER = 4'h4;

  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int TRIG_MODE_BIT = 3;
  localparam int TRIG_STAT_BIT = 6;
  localparam int CTL_ONE_USED = 4;

  localparam logic [CTL_W-1:0] CTL_RESET = 16'h0000;
  localparam logic [TMR_W-1:0] CMP_RESET = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    MODE_OFF       = 3'b000,
    MODE_ONE_HIGH  = 3'b001,
    MODE_ONE_LOW   = 3'b010,
    MODE_TOGGLE    = 3'b011,
    MODE_DBL_SHOT  = 3'b100,
    MODE_DBL_CONT  = 3'b101,
    MODE_PWM_EDGE  = 3'b110,
    MODE_PWM_CTR   = 3'b111
  } compare_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CTL_W-1:0]  wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;
endpackage

// ===== cmp_reg.sv
`timescale 1ns/1ps
module cmp_reg (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       wr,
  input  wire logic [ocmp_pkg::TMR_W-1:0] wdata,
  input  wire logic                       buffered,
  input  wire logic                       reload,
  output logic      [ocmp_pkg::TMR_W-1:0] shadow,
  output logic      [ocmp_pkg::TMR_W-1:0] active
);
  import ocmp_pkg::*;

  wire take_direct = wr & ~buffered;
  wire take_reload = buffered & reload;

  // software side copy
  always_ff @(posedge clk) begin
    if (rst) begin
      shadow <= CMP_RESET;
    end else if (wr) begin
      shadow <= wdata;
    end
  end

  // copy used by the comparator
  always_ff @(posedge clk) begin
    if (rst) begin
      active <= CMP_RESET;
    end else if (take_direct) begin
      active <= wdata;
    end else if (take_reload) begin
      active <= shadow;
    end
  end
endmodule

// ===== ocmp_load.sv
`timescale 1ns/1ps
// far side: counts rising edges seen on the compare output
module ocmp_load (
  input  wire logic clk,
  input  wire logic pin,
  output int        rises
);
  logic last = 1'b0;
  initial rises = 0;
  always @(negedge clk) begin
    if (pin === 1'b1 && last !== 1'b1) rises <= rises + 1;
    last <= pin;
  end
endmodule

// ===== output_compare_mode_logic_tb.sv
`timescale 1ns/1ps
module output_compare_mode_logic_tb;
  import ocmp_pkg::*;
  logic             clk;
  logic             rst;
  reg_req_t         req;
  logic [CTL_W-1:0] rdata;
  logic             trigger_event;
  logic [TMR_W-1:0] tmr;
  logic             pin;
  int               rises;
  int               error_cnt = 0;
  int               num_checks = 0;
  logic [31:0]      seed = 32'h00005f47;
  logic [TMR_W-1:0] p;
  logic [TMR_W-1:0] s;
  logic [CTL_W-1:0] v;
  logic [3:0]       b;
  int               exp_rises;

  output_compare_mode_logic i_dut (.clk(clk), .rst(rst), .req(req),
    .rdata(rdata), .trigger_event(trigger_event),
    .channel_timer_value(tmr), .compare_output_pin(pin));
  ocmp_load i_load (.clk(clk), .pin(pin), .rises(rises));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // pin after init, primary, secondary, second primary
  function automatic logic [3:0] seq_of(input logic [2:0] m);
    case (m)
      3'b001: return 4'b0111;
      3'b010: return 4'b1000;
      3'b011: return 4'b0110;
      3'b100: return 4'b0100;
      default: return 4'b0101;
    endcase
  endfunction

  function automatic int ups(input logic [3:0] q);
    int   n;
    logic pr;
    n = 0;
    pr = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (q[i] && !pr) n++;
      pr = q[i];
    end
    return n;
  endfunction

  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic wait_tmr(input logic [TMR_W-1:0] t);
    int k;
    for (k = 0; k < 400; k++) begin
      @(negedge clk);
      if (tmr === t) break;
    end
    if (k == 400) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic pin_is(input string n, input logic e);
    cmp(n, {15'h0000, e}, {15'h0000, pin});
  endtask

  initial begin
    rst = 1'b1;
    req = '0;
    trigger_event = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++) begin
      rd(a[ADDR_W-1:0], v);
      cmp("reset read", 16'h0000, v);
    end
    seed = xs(seed);
    p = 16'h0010 + {8'h00, seed[7:0]};
    s = p + 16'h0010;
    wr(ADDR_PRIMARY, p);
    wr(ADDR_SECONDARY, s);
    rd(ADDR_SECONDARY, v);
    cmp("secondary", s, v);
    seed = xs(seed);
    wr(ADDR_CTL_ONE, seed[15:0] & 16'hfff8);
    rd(ADDR_CTL_ONE, v);
    cmp("control one", seed[15:0] & 16'h0008, v);
    exp_rises = 0;
    for (int i = 1; i < 8; i++) begin
      if (i == 6) continue;
      b = seq_of(i[2:0]);
      exp_rises += ups(b);
      wr(ADDR_CTL_ONE, 16'h0000);
      wr(ADDR_TIMER, p - 16'h0003);
      @(negedge clk);
      pin_is("pin off", 1'b0);
      cmp("timer hold", p - 16'h0003, tmr);
      wr(ADDR_CTL_ONE, {13'h0000, i[2:0]});
      wait_tmr(p);
      pin_is("pin init", b[3]);
      wait_tmr(p + 16'h0001);
      pin_is("primary", b[2]);
      wait_tmr(s + 16'h0001);
      pin_is("secondary", b[1]);
      wr(ADDR_TIMER, p - 16'h0003);
      wait_tmr(p + 16'h0001);
      pin_is("again", b[0]);
    end
    wr(ADDR_CTL_ONE, 16'h0000);
    cmp("rises", exp_rises[15:0], rises[15:0]);
    wr(ADDR_CTL_ONE, 16'h0006);
    wr(ADDR_TIMER, 16'hfffe);
    wait_tmr(16'h0001);
    pin_is("pwm rise", 1'b1);
    wr(ADDR_PRIMARY, p + 16'h0008);
    wait_tmr(p + 16'h0001);
    pin_is("pwm fall", 1'b0);
    wr(ADDR_TIMER, 16'hfffe);
    wait_tmr(p + 16'h0001);
    pin_is("pwm reload", 1'b1);
    wait_tmr(p + 16'h0009);
    pin_is("pwm new fall", 1'b0);
    wr(ADDR_CTL_ONE, 16'h0003);
    wr(ADDR_CTL_TWO, 16'h0040);
    wr(ADDR_TIMER, s - 16'h0003);
    wait_tmr(s + 16'h0001);
    rd(ADDR_CTL_TWO, v);
    cmp("flag kept", 16'h0040, v & 16'h0040);
    wr(ADDR_CTL_ONE, 16'h000b);
    wr(ADDR_TIMER, s - 16'h0003);
    wait_tmr(s + 16'h0001);
    rd(ADDR_CTL_TWO, v);
    cmp("flag hw clear", 16'h0000, v & 16'h0040);
    @(posedge clk);
    trigger_event <= 1'b1;
    @(posedge clk);
    trigger_event <= 1'b0;
    rd(ADDR_CTL_TWO, v);
    cmp("flag set", 16'h0040, v & 16'h0040);
    wr(ADDR_CTL_TWO, 16'h0000);
    rd(ADDR_CTL_TWO, v);
    cmp("flag sw clear", 16'h0000, v & 16'h0040);
    report_and_stop();
  end
endmodule
